/* File: design/clock_tick_gen.sv */
/*
 * Counter clock source selector and prescaler, as one-cycle enable pulses.
 * Assumes oscillator pins are free-running and slower than half of clk.
 */
`timescale 1ns/1ns
`default_nettype none

`include "signal_measure_timer_defs.svh"

module clock_tick_gen (
    input  wire logic                                  clk,
    input  wire logic                                  rst_n,
    input  wire signal_measure_timer_pkg::clock_source_t clk_src,
    input  wire logic [1:0]                            prescale_select,
    input  wire logic                                  fast_osc_in,
    input  wire logic                                  slow_osc_in,
    input  wire logic                                  medium_osc_in,
    output logic                                       tick
);
    import signal_measure_timer_pkg::*;

    logic [2:0] osc_sync;
    logic [2:0] osc_prev_ff;
    logic [1:0] div4_ff;
    logic [2:0] pre_cnt_ff;
    logic       src_tick;
    logic [2:0] pre_mask;

    input_sync #(.WIDTH(3)) u_osc_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in ({medium_osc_in, slow_osc_in, fast_osc_in}),
        .sync_out (osc_sync)
    );

    // Rising edge history of the synchronised oscillators, and the fosc/4 divider
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            osc_prev_ff <= 3'h0;
            div4_ff     <= 2'h0;
        end else begin
            osc_prev_ff <= osc_sync;
            div4_ff     <= div4_ff + 2'h1;
        end
    end

    // Source select; unused codes give no ticks so the counter simply stalls
    always_comb begin
        unique case (clk_src)
            SRC_FOSC:       src_tick = 1'b1;
            SRC_FOSC_DIV4:  src_tick = (div4_ff == `FOSC_DIV4_LAST);
            SRC_FAST_OSC:   src_tick = osc_sync[0] & ~osc_prev_ff[0];
            SRC_SLOW_OSC:   src_tick = osc_sync[1] & ~osc_prev_ff[1];
            SRC_MEDIUM_OSC: src_tick = osc_sync[2] & ~osc_prev_ff[2];
            default:        src_tick = 1'b0;
        endcase
    end

    // Divide by 1, 2, 4 or 8
    assign pre_mask = 3'((4'h1 << prescale_select) - 4'h1); // RULE_18

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pre_cnt_ff <= 3'h0;
        end else if (src_tick) begin
            pre_cnt_ff <= ((pre_cnt_ff & pre_mask) == pre_mask) ? 3'h0 : pre_cnt_ff + 3'h1;
        end
    end

    assign tick = src_tick && ((pre_cnt_ff & pre_mask) == pre_mask); // RULE_03
endmodule // clock_tick_gen

`default_nettype wire

/* File: design/input_sync.sv */
/*
 * Bank of two-flop synchronisers for pins from outside the clock domain.
 * Assumes a single system clock and a synchronous active-low reset.
 */
`timescale 1ns/1ns
`default_nettype none

module input_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;

    // First stage is read only by the second stage
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_sync
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    meta_ff[i]  <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_ff[i]  <= async_in[i];
                    sync_out[i] <= meta_ff[i];
                end
            end
        end
    endgenerate
endmodule // input_sync

`default_nettype wire

/* File: design/signal_measure_timer.sv */
/*
 * Signal measurement timer core: 24-bit counter, period match, two capture
 * latches, polarity control and status flags behind a plain register port.
 * Assumes a register master that holds strobes one cycle and never overlaps
 * them; window, signal and clock inputs and oscillators are asynchronous pins.
 */
// The plain strobed port and the register addresses were left to the implementer.
// Summary of operation
// RULE_01: A 24-bit counter is the time base of every mode.
// RULE_02: A three-bit selector picks fosc, fosc/4, fast, slow or medium oscillator.
// RULE_03: A two-bit prescaler divides it; that rate drives counter and synchronisers.
// RULE_04: Counter equal to period limit rolls over to zero and raises period match.
// RULE_05: Software sets period limit above the longest expected signal or window.
// RULE_06: Writing the status clear bit resets the counter to zero.
// RULE_07: Software touches the counter only while the run request is off.
// RULE_08: A 24-bit width latch captures the counter on a mode-chosen trigger.
// RULE_09: Writing the width update bit copies the counter into the width latch.
// RULE_10: A 24-bit period latch captures the counter; its update bit copies it.
// RULE_11: Halt on match stops rollover; match persists until clear or rewrite.
// RULE_12: Window, signal and clock inputs each have a polarity select in control 0.
// RULE_13: Status input flags read the same whatever polarity is programmed.
// RULE_14: Window flag valid while running, delayed by synchronisers outside counter mode.
// RULE_15: Signal flag valid while running, delayed by synchronisers outside counter mode.
// RULE_16: Run state flag follows the run request after synchroniser delay; in counter mode the code copies the run request directly.
// RULE_17: Counter counts up once per prescaled tick while running, else holds.
// RULE_18: Prescale codes 0 to 3 divide by 1, 2, 4 and 8.
`timescale 1ns/1ns
`default_nettype none

`include "signal_measure_timer_defs.svh"

module signal_measure_timer (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [23:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [23:0] reg_rdata,
    input  wire logic        window_in,
    input  wire logic        signal_in,
    input  wire logic        clock_in,
    input  wire logic        fast_osc_in,
    input  wire logic        slow_osc_in,
    input  wire logic        medium_osc_in,
    output logic             period_match
);
    import signal_measure_timer_pkg::*;

    // Registers
    count_t                   measure_counter_ff;
    count_t                   period_limit_ff;
    count_t                   width_latch_ff;
    count_t                   period_latch_ff;
    logic [`C0_WIDTH-1:0]     control0_ff;
    logic [`C1_WIDTH-1:0]     control1_ff;
    clock_source_t            clock_select_ff;
    logic                     run_pipe_ff;
    logic                     run_state_ff;

    // Pin path
    logic [2:0]               pin_sync;
    logic [2:0]               pin_tick_ff;
    logic [2:0]               pin_prev_ff;
    logic [2:0]               pin_active;

    // Decode and next values
    logic                     tick;
    logic                     wr_counter;
    logic                     wr_status;
    logic                     do_clear;
    logic                     at_limit;
    logic                     count_en;
    logic                     match_evt;
    logic                     sig_rise;
    logic                     sig_fall;
    logic                     clk_edge;
    logic                     window_flag;
    logic                     signal_flag;

    count_t                   nxt_counter;
    logic [23:0]              nxt_rdata;

    // Decode of one register address against a write strobe
    function automatic logic hit(input logic [4:0] a, input logic [4:0] off, input logic s);
        return s && (a == off);
    endfunction

    assign wr_counter = hit(reg_addr, `ADDR_MEASURE_COUNTER, reg_wr);
    assign wr_status  = hit(reg_addr, `ADDR_MEASURE_STATUS, reg_wr);
    assign do_clear   = wr_status && reg_wdata[`ST_COUNTER_CLEAR];

    clock_tick_gen u_tick (
        .clk             (clk),
        .rst_n           (rst_n),
        .clk_src         (clock_select_ff),
        .prescale_select (control0_ff[`C0_PRESCALE_HI:`C0_PRESCALE_LO]),
        .fast_osc_in     (fast_osc_in),
        .slow_osc_in     (slow_osc_in),
        .medium_osc_in   (medium_osc_in),
        .tick            (tick)
    );

    // Pins cross into the clock domain before anything looks at them
    input_sync #(.WIDTH(3)) u_pin_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in ({clock_in, signal_in, window_in}),
        .sync_out (pin_sync)
    );

    // Further input stage runs at the prescaled rate, so its delay scales with it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_tick_ff <= 3'h0;
            pin_prev_ff <= 3'h0;
        end else if (tick) begin
            pin_tick_ff <= pin_sync; // RULE_03
            pin_prev_ff <= pin_active;
        end
    end

    // Per-input polarity: a set select means active low and falling edge
    assign pin_active = pin_tick_ff ^ {control0_ff[`C0_CLOCK_POLARITY],
                                       control0_ff[`C0_SIGNAL_POLARITY],
                                       control0_ff[`C0_WINDOW_POLARITY]}; // RULE_12

    // Edges at tick rate; a polarity change can fake one
    assign sig_rise = tick && pin_active[1] && !pin_prev_ff[1];
    assign sig_fall = tick && !pin_active[1] && pin_prev_ff[1];
    assign clk_edge = tick && pin_active[2] && !pin_prev_ff[2];

    // Flags report the active state, so software never folds polarity in itself
    assign window_flag = run_state_ff && pin_active[0]; // RULE_13 RULE_14
    assign signal_flag = run_state_ff && pin_active[1]; // RULE_13 RULE_15

    // Run state passes the synchronising stages except in counter mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            run_pipe_ff  <= 1'b0;
            run_state_ff <= 1'b0;
        end else if (control1_ff[`C1_COUNTER_MODE]) begin
            run_pipe_ff  <= control1_ff[`C1_RUN_REQUEST];
            run_state_ff <= control1_ff[`C1_RUN_REQUEST];
        end else if (tick) begin
            run_pipe_ff  <= control1_ff[`C1_RUN_REQUEST]; // RULE_16
            run_state_ff <= run_pipe_ff;
        end
    end

    // Counting condition: clock pin edges in counter mode, else the prescaled tick,
    // optionally gated by the window
    assign count_en = run_state_ff
                    && (control1_ff[`C1_COUNTER_MODE] ? clk_edge : tick)
                    && (!control1_ff[`C1_GATE_EN] || pin_active[0]); // RULE_17
    assign at_limit  = (measure_counter_ff == period_limit_ff);
    assign match_evt = count_en && at_limit; // RULE_04

    // Counter next value: software write, then clear, then match, then count
    always_comb begin
        nxt_counter = measure_counter_ff;
        if (wr_counter) begin
            nxt_counter = reg_wdata;
        end else if (do_clear) begin
            nxt_counter = `COUNTER_RESET; // RULE_06
        end else if (match_evt) begin
            if (!control0_ff[`C0_HALT_ON_MATCH]) begin
                nxt_counter = `COUNTER_RESET; // RULE_04
            end
        end else if (count_en) begin
            nxt_counter = measure_counter_ff + 24'h00_0001; // RULE_01 RULE_17
        end
    end

    // Counter store; direct writes are not atomic against counting, so
    // software should stop the timer first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            measure_counter_ff <= `COUNTER_RESET;
        end else begin
            measure_counter_ff <= nxt_counter;
        end
    end

    // Period match: a pulse normally; held while halted until cleared or rewritten
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            period_match <= 1'b0;
        end else if (match_evt) begin
            period_match <= 1'b1; // RULE_04 RULE_11
        end else if (wr_counter || do_clear || !control0_ff[`C0_HALT_ON_MATCH]) begin
            period_match <= 1'b0;
        end
    end

    // Width latch: software update, or the inactive signal edge in capture mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            width_latch_ff <= `COUNTER_RESET;
        end else if (wr_status && reg_wdata[`ST_WIDTH_LATCH_UPDATE]) begin
            width_latch_ff <= measure_counter_ff; // RULE_09
        end else if (control1_ff[`C1_CAPTURE_EN] && run_state_ff && sig_fall) begin
            width_latch_ff <= measure_counter_ff; // RULE_08
        end
    end

    // Period latch: software update, or the active signal edge in capture mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            period_latch_ff <= `COUNTER_RESET;
        end else if (wr_status && reg_wdata[`ST_PERIOD_LATCH_UPDATE]) begin
            period_latch_ff <= measure_counter_ff; // RULE_10
        end else if (control1_ff[`C1_CAPTURE_EN] && run_state_ff && sig_rise) begin
            period_latch_ff <= measure_counter_ff; // RULE_10
        end
    end

    // Software-written configuration registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            period_limit_ff <= `PERIOD_LIMIT_RESET;
            control0_ff     <= '0;
            control1_ff     <= '0;
            clock_select_ff <= SRC_FOSC;
        end else if (reg_wr) begin
            if (reg_addr == `ADDR_PERIOD_LIMIT) begin
                period_limit_ff <= reg_wdata; // RULE_05
            end
            if (reg_addr == `ADDR_MEASURE_CONTROL0) begin
                control0_ff <= reg_wdata[`C0_WIDTH-1:0]; // RULE_12
            end
            if (reg_addr == `ADDR_MEASURE_CONTROL1) begin
                control1_ff <= reg_wdata[`C1_WIDTH-1:0];
            end
            if (reg_addr == `ADDR_CLOCK_SELECT) begin
                clock_select_ff <= clock_source_t'(reg_wdata[`CLOCK_SELECT_WIDTH-1:0]); // RULE_02
            end
        end
    end

    // Read mux; unmapped addresses and the action bits read as zero
    always_comb begin
        nxt_rdata = 24'h00_0000;
        unique case (reg_addr)
            `ADDR_MEASURE_COUNTER:  nxt_rdata = measure_counter_ff;
            `ADDR_PERIOD_LIMIT:     nxt_rdata = period_limit_ff;
            `ADDR_WIDTH_LATCH:      nxt_rdata = width_latch_ff;
            `ADDR_PERIOD_LATCH:     nxt_rdata = period_latch_ff;
            `ADDR_MEASURE_CONTROL0: nxt_rdata[`C0_WIDTH-1:0] = control0_ff;
            `ADDR_MEASURE_CONTROL1: nxt_rdata[`C1_WIDTH-1:0] = control1_ff;
            `ADDR_CLOCK_SELECT:     nxt_rdata[`CLOCK_SELECT_WIDTH-1:0] = clock_select_ff;
            `ADDR_MEASURE_STATUS: begin
                nxt_rdata[`ST_RUN_STATE]    = run_state_ff; // RULE_16
                nxt_rdata[`ST_SIGNAL_LEVEL] = signal_flag;
                nxt_rdata[`ST_WINDOW_LEVEL] = window_flag;
                nxt_rdata[`ST_PERIOD_MATCH] = period_match;
            end
            default:                nxt_rdata = 24'h00_0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 24'h00_0000;
        end else begin
            reg_rdata <= reg_rd ? nxt_rdata : 24'h00_0000;
        end
    end

    // Checks of the counting, latch update, status read and run state behaviour
    sequence s_roll;
        match_evt && !control0_ff[`C0_HALT_ON_MATCH] && !wr_counter && !do_clear;
    endsequence

    property p_rollover;
        @(posedge clk) disable iff (!rst_n)
        s_roll |=> (measure_counter_ff == `COUNTER_RESET) && period_match;
    endproperty
    a_rollover: assert property (p_rollover) else $error("no rollover at limit"); // RULE_04

    property p_count_up;
        @(posedge clk) disable iff (!rst_n)
        (count_en && !at_limit && !wr_counter && !do_clear)
        |=> measure_counter_ff == $past(measure_counter_ff) + 24'h00_0001;
    endproperty
    a_count_up: assert property (p_count_up) else $error("counter did not step"); // RULE_17

    property p_hold_stopped;
        @(posedge clk) disable iff (!rst_n)
        (!run_state_ff && !wr_counter && !do_clear) |=> $stable(measure_counter_ff);
    endproperty
    a_hold_stopped: assert property (p_hold_stopped) else $error("counter moved while stopped"); // RULE_17

    property p_clear;
        @(posedge clk) disable iff (!rst_n)
        (do_clear && !wr_counter) |=> measure_counter_ff == `COUNTER_RESET;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero counter"); // RULE_06

    property p_width_update;
        @(posedge clk) disable iff (!rst_n)
        (wr_status && reg_wdata[`ST_WIDTH_LATCH_UPDATE])
        |=> width_latch_ff == $past(measure_counter_ff);
    endproperty
    a_width_update: assert property (p_width_update) else $error("width latch not updated"); // RULE_09

    property p_period_update;
        @(posedge clk) disable iff (!rst_n)
        (wr_status && reg_wdata[`ST_PERIOD_LATCH_UPDATE])
        |=> period_latch_ff == $past(measure_counter_ff);
    endproperty
    a_period_update: assert property (p_period_update) else $error("period latch not updated"); // RULE_10

    sequence s_halted;
        period_match && control0_ff[`C0_HALT_ON_MATCH] && !wr_counter && !do_clear;
    endsequence

    property p_halt;
        @(posedge clk) disable iff (!rst_n)
        s_halted |=> period_match && $stable(measure_counter_ff);
    endproperty
    a_halt: assert property (p_halt) else $error("halted match lost"); // RULE_11

    property p_status_read;
        @(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == `ADDR_MEASURE_STATUS)
        |=> reg_rdata[`ST_WINDOW_LEVEL] == $past(window_flag)
            && reg_rdata[`ST_RUN_STATE] == $past(run_state_ff);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status flags misread"); // RULE_14

    property p_run_direct;
        @(posedge clk) disable iff (!rst_n)
        control1_ff[`C1_COUNTER_MODE] ##1 control1_ff[`C1_COUNTER_MODE]
        |-> run_state_ff == $past(control1_ff[`C1_RUN_REQUEST]);
    endproperty
    a_run_direct: assert property (p_run_direct) else $error("run state lags in counter mode"); // RULE_16

endmodule // signal_measure_timer

`default_nettype wire

/* File: design/signal_measure_timer_defs.svh */
/*
 * Register offsets, field positions, reset values and fixed counts of the
 * signal measurement timer core.
 * Assumes byte addresses on a five-bit register port and 24-bit data.
 */
`ifndef SIGNAL_MEASURE_TIMER_DEFS_SVH
`define SIGNAL_MEASURE_TIMER_DEFS_SVH

// Register byte offsets
`define ADDR_MEASURE_COUNTER   5'h00
`define ADDR_PERIOD_LIMIT      5'h04
`define ADDR_WIDTH_LATCH       5'h08
`define ADDR_PERIOD_LATCH      5'h0C
`define ADDR_MEASURE_CONTROL0  5'h10
`define ADDR_MEASURE_CONTROL1  5'h14
`define ADDR_MEASURE_STATUS    5'h18
`define ADDR_CLOCK_SELECT      5'h1C

// Control 0 fields
`define C0_PRESCALE_LO         0
`define C0_PRESCALE_HI         1
`define C0_HALT_ON_MATCH       2
`define C0_WINDOW_POLARITY     3
`define C0_SIGNAL_POLARITY     4
`define C0_CLOCK_POLARITY      5
`define C0_WIDTH               6

// Control 1 fields
`define C1_RUN_REQUEST         0
`define C1_COUNTER_MODE        1
`define C1_CAPTURE_EN          2
`define C1_GATE_EN             3
`define C1_WIDTH               4

// Status fields: write-one actions and read-back flags
`define ST_COUNTER_CLEAR       0
`define ST_WIDTH_LATCH_UPDATE  1
`define ST_PERIOD_LATCH_UPDATE 2
`define ST_RUN_STATE           3
`define ST_SIGNAL_LEVEL        4
`define ST_WINDOW_LEVEL        5
`define ST_PERIOD_MATCH        6

// Reset values and fixed figures
`define COUNTER_RESET          24'h00_0000
`define PERIOD_LIMIT_RESET     24'hFF_FFFF
`define CLOCK_SELECT_WIDTH     3
`define FOSC_DIV4_LAST         2'h3

`endif

/* File: design/signal_measure_timer_pkg.sv */
/*
 * Types shared by the signal measurement timer files.
 * Assumes the defs header for widths and offsets.
 */
package signal_measure_timer_pkg;

    // Counter clock source choices
    typedef enum logic [2:0] {
        SRC_FOSC      = 3'h0,
        SRC_FOSC_DIV4 = 3'h1,
        SRC_FAST_OSC  = 3'h2,
        SRC_SLOW_OSC  = 3'h3,
        SRC_MEDIUM_OSC = 3'h4
    } clock_source_t;

    typedef logic [23:0] count_t;

endpackage

/* File: test/pin_source_model.sv */
/*
 * Far-side model of the timer pins: window, signal and clock levels plus
 * three free-running oscillators.
 * Assumes rising clk edges fall at 4k+2 ns, so oscillator edges never meet them.
 */
`timescale 1ns/1ns
`default_nettype none

module pin_source_model #(
    parameter int FAST_HALF   = 20,
    parameter int SLOW_HALF   = 28,
    parameter int MEDIUM_HALF = 36
) (
    input  wire logic win_lvl,
    input  wire logic sig_lvl,
    input  wire logic clk_lvl,
    output logic      window_in,
    output logic      signal_in,
    output logic      clock_in,
    output var logic  fast_osc_in,
    output var logic  slow_osc_in,
    output var logic  medium_osc_in
);
    // Pins follow the levels the bench asks for; no polarity applied here
    assign window_in = win_lvl;
    assign signal_in = sig_lvl;
    assign clock_in  = clk_lvl;

    // Oscillators run free from time zero; whole-clk periods keep spacing exact
    initial begin
        fast_osc_in   = 1'b0;
        slow_osc_in   = 1'b0;
        medium_osc_in = 1'b0;
    end
    always #(FAST_HALF) fast_osc_in = ~fast_osc_in;
    always #(SLOW_HALF) slow_osc_in = ~slow_osc_in;
    always #(MEDIUM_HALF) medium_osc_in = ~medium_osc_in;
endmodule // pin_source_model

`default_nettype wire

/* File: test/signal_measure_timer_bench.sv */
/*
 * Self-checking bench for the signal measurement timer core.
 * Assumes the pin model's oscillator periods of 10, 14 and 18 clk.
 */
`timescale 1ns/1ns
`default_nettype none

`include "signal_measure_timer_defs.svh"

`define CHECK_EQ(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module signal_measure_timer_bench;
    import signal_measure_timer_pkg::*;
    logic        clk, rst_n, reg_wr, reg_rd, win_lvl, sig_lvl;
    logic [4:0]  reg_addr;
    logic [23:0] reg_wdata, reg_rdata, rd_val;
    logic        window_in, signal_in, clock_in, period_match;
    logic        fast_osc_in, slow_osc_in, medium_osc_in;
    int          num_errors, check_count, n;

    signal_measure_timer signal_measure_timer_inst (.clk(clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .window_in(window_in), .signal_in(signal_in),
        .clock_in(clock_in), .fast_osc_in(fast_osc_in), .slow_osc_in(slow_osc_in),
        .medium_osc_in(medium_osc_in), .period_match(period_match));
    pin_source_model pin_source_model_inst (.win_lvl(win_lvl), .sig_lvl(sig_lvl),
        .clk_lvl(sig_lvl), .window_in(window_in), .signal_in(signal_in), .clock_in(clock_in),
        .fast_osc_in(fast_osc_in), .slow_osc_in(slow_osc_in), .medium_osc_in(medium_osc_in));

    // 250 MHz system clock
    initial clk = 1'b0;
    always #2 clk = ~clk;

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // One-cycle strobes; read data sampled in the single cycle it stands
    task automatic reg_write(input logic [4:0] a, input logic [23:0] d);
        @(posedge clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
        @(posedge clk) reg_wr <= 1'b0;
    endtask
    task automatic expect_reg(input logic [4:0] a, input logic [23:0] exp);
        @(posedge clk) begin reg_addr <= a; reg_rd <= 1'b1; end
        @(posedge clk) reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
        `CHECK_EQ(rd_val, exp)
    endtask

    // Counts cycles to the next settled match; a missed bound ends the run if required
    task automatic wait_match(input int bound, input bit must, output int cnt);
        cnt = 0;
        do begin @(posedge clk); #1 cnt++; end while (period_match !== 1'b1 && cnt < bound);
        if (must && cnt >= bound) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, cnt, bound);
            report_and_stop;
        end
    endtask

    // Counter is touched only with the run request off
    task automatic setup(input logic [2:0] src, input logic [23:0] c0, input logic [23:0] lim);
        reg_write(`ADDR_MEASURE_CONTROL1, 24'h00_0000);
        reg_write(`ADDR_CLOCK_SELECT, {21'h0, src});
        reg_write(`ADDR_MEASURE_CONTROL0, c0);
        reg_write(`ADDR_PERIOD_LIMIT, lim);
        reg_write(`ADDR_MEASURE_COUNTER, 24'h00_0000);
    endtask

    task automatic test_reset;
        expect_reg(`ADDR_MEASURE_COUNTER, 24'h00_0000);
        expect_reg(`ADDR_PERIOD_LIMIT, 24'hFF_FFFF);
        expect_reg(`ADDR_MEASURE_STATUS, 24'h00_0000);
        reg_write(5'h1D, 24'hA5_A5A5);
        expect_reg(5'h1D, 24'h00_0000);
        $display("test_reset done");
    endtask

    task automatic test_latches;
        setup(SRC_FOSC, 24'h00_0000, 24'hFF_FFFF);
        reg_write(`ADDR_MEASURE_COUNTER, 24'h12_3456);
        expect_reg(`ADDR_MEASURE_COUNTER, 24'h12_3456);
        reg_write(`ADDR_MEASURE_STATUS, 24'h00_0002);
        reg_write(`ADDR_MEASURE_COUNTER, 24'hAB_CDEF);
        reg_write(`ADDR_MEASURE_STATUS, 24'h00_0004);
        reg_write(`ADDR_WIDTH_LATCH, 24'hFF_FFFF);
        expect_reg(`ADDR_WIDTH_LATCH, 24'h12_3456);
        expect_reg(`ADDR_PERIOD_LATCH, 24'hAB_CDEF);
        reg_write(`ADDR_MEASURE_STATUS, 24'h00_0001);
        expect_reg(`ADDR_MEASURE_COUNTER, 24'h00_0000);
        $display("test_latches done");
    endtask

    // Limit 5 gives six counts per rollover
    task automatic check_rate(input logic [2:0] src, input logic [1:0] ps, input int per);
        setup(src, {22'h0, ps}, 24'h00_0005);
        reg_write(`ADDR_MEASURE_CONTROL1, 24'h00_0001);
        wait_match(4000, 1'b1, n);
        wait_match(4000, 1'b1, n);
        `CHECK_EQ(n, 6 * per)
    endtask

    task automatic test_rates;
        for (int p = 0; p < 4; p++) check_rate(SRC_FOSC, p[1:0], 1 << p);
        check_rate(SRC_FOSC_DIV4, 2'h0, 4);
        check_rate(SRC_FAST_OSC, 2'h1, 20);
        check_rate(SRC_SLOW_OSC, 2'h0, 14);
        check_rate(SRC_MEDIUM_OSC, 2'h0, 18);
        setup(3'h5, 24'h00_0000, 24'h00_0002);
        reg_write(`ADDR_MEASURE_CONTROL1, 24'h00_0001);
        wait_match(200, 1'b0, n);
        `CHECK_EQ(n, 200)
        $display("test_rates done");
    endtask

    task automatic test_halt;
        setup(SRC_FOSC, 24'h00_0004, 24'h00_0003);
        reg_write(`ADDR_MEASURE_CONTROL1, 24'h00_0001);
        wait_match(100, 1'b1, n);
        repeat (6) @(posedge clk);
        #1 `CHECK_EQ(period_match, 1'b1)
        reg_write(`ADDR_MEASURE_CONTROL1, 24'h00_0000);
        repeat (6) @(posedge clk);
        expect_reg(`ADDR_MEASURE_COUNTER, 24'h00_0003);
        expect_reg(`ADDR_MEASURE_STATUS, 24'h00_0040);
        reg_write(`ADDR_MEASURE_STATUS, 24'h00_0001);
        repeat (2) @(posedge clk);
        #1 `CHECK_EQ(period_match, 1'b0)
        expect_reg(`ADDR_MEASURE_COUNTER, 24'h00_0000);
        $display("test_halt done");
    endtask

    // Flags must read the same for both polarity settings
    task automatic test_flags;
        for (int p = 0; p < 2; p++) begin
            setup(SRC_FOSC, p ? 24'h00_0018 : 24'h00_0000, 24'hFF_FFFF);
            win_lvl <= ~p[0];
            sig_lvl <= ~p[0];
            reg_write(`ADDR_MEASURE_CONTROL1, p ? 24'h00_0003 : 24'h00_0007);
            repeat (8) @(posedge clk);
            expect_reg(`ADDR_MEASURE_STATUS, 24'h00_0038);
            win_lvl <= p[0];
            sig_lvl <= p[0];
            repeat (8) @(posedge clk);
            expect_reg(`ADDR_MEASURE_STATUS, 24'h00_0008);
            expect_reg(`ADDR_MEASURE_COUNTER, 24'h00_0001);
        end
        reg_write(`ADDR_MEASURE_CONTROL1, 24'h00_0000);
        repeat (8) @(posedge clk);
        expect_reg(`ADDR_MEASURE_STATUS, 24'h00_0000);
        expect_reg(`ADDR_WIDTH_LATCH, 24'h00_0001);
        $display("test_flags done");
    endtask

    // Main sequence with a second reset in mid-run
    initial begin
        {rst_n, reg_wr, reg_rd, win_lvl, sig_lvl} = 5'h00;
        reg_addr = 5'h00;
        reg_wdata = 24'h00_0000;
        num_errors = 0;
        check_count = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        test_reset;
        test_latches;
        test_rates;
        test_halt;
        @(posedge clk) rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        test_reset;
        test_flags;
        report_and_stop;
    end
endmodule // signal_measure_timer_bench

`default_nettype wire
